// [uhmp_pkg.sv]
// Constants shared by the UART host and modem pin block
package uhmp_pkg;

    // Register offsets on the register select lines
    localparam logic [2:0] UHMP_OFF_DATA = 3'h0;
    localparam logic [2:0] UHMP_OFF_IER = 3'h1;
    localparam logic [2:0] UHMP_OFF_IIR = 3'h2;
    localparam logic [2:0] UHMP_OFF_LCR = 3'h3;
    localparam logic [2:0] UHMP_OFF_MCR = 3'h4;
    localparam logic [2:0] UHMP_OFF_LSR = 3'h5;
    localparam logic [2:0] UHMP_OFF_MSR = 3'h6;
    localparam logic [2:0] UHMP_OFF_SCR = 3'h7;

    // Interrupt enable bits
    localparam int UHMP_IER_RDA = 0;
    localparam int UHMP_IER_THRE = 1;
    localparam int UHMP_IER_RLS = 2;
    localparam int UHMP_IER_MS = 3;

    // Line control and modem control bits
    localparam int UHMP_LCR_DLAB = 7;
    localparam int UHMP_MCR_DTR = 0;
    localparam int UHMP_MCR_RTS = 1;
    localparam int UHMP_MCR_OUT2 = 3;
    localparam int UHMP_MCR_LOOP = 4;
    localparam int UHMP_MCR_AUTO_CTS = 5;

    // Modem status bits
    localparam int UHMP_MSR_DCTS = 0;
    localparam int UHMP_MSR_DDSR = 1;
    localparam int UHMP_MSR_DDCD = 3;
    localparam int UHMP_MSR_CTS = 4;
    localparam int UHMP_MSR_DSR = 5;
    localparam int UHMP_MSR_DCD = 7;

    // Identification codes in the low nibble, FIFO flags above
    localparam logic [3:0] UHMP_IIR_NONE = 4'h1;
    localparam logic [3:0] UHMP_IIR_RLS = 4'h6;
    localparam logic [3:0] UHMP_IIR_RDA = 4'h4;
    localparam logic [3:0] UHMP_IIR_TMO = 4'hc;
    localparam logic [3:0] UHMP_IIR_THRE = 4'h2;
    localparam logic [3:0] UHMP_IIR_MS = 4'h0;
    localparam logic [1:0] UHMP_IIR_FIFO_ON = 2'h3;

    // Reset values
    localparam logic [7:0] UHMP_RST_BYTE = 8'h00;
    localparam logic [15:0] UHMP_RST_DIV = 16'h0000;
    // Pin synchronisers start at idle levels: active-low selects and modem inputs high
    localparam logic [20:0] UHMP_SYNC_RST = 21'h007001;

    // Host access sequencer, one-hot
    typedef enum logic [2:0] {
        UHMP_ST_IDLE = 3'b001,
        UHMP_ST_READ = 3'b010,
        UHMP_ST_WRITE = 3'b100
    } uhmp_state_t;

endpackage

// [uhmp_top.sv]
// Host bus, baud clock, interrupt and modem pins of a 16550-style UART
`timescale 1ns/10ps
module uhmp_top
    import uhmp_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // Host bus pins
    input wire logic chip_sel_high_a_i,
    input wire logic chip_sel_high_b_i,
    input wire logic chip_sel_low_n_i,
    input wire logic addr_strobe_n_i,
    input wire logic [2:0] register_select_i,
    input wire logic read_strobe_i,
    input wire logic write_strobe_i,
    input wire logic [7:0] host_data_bus_i,
    output logic [7:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    output logic driver_disable_out_o,
    output logic interrupt_o,
    // Baud clocks
    output logic tx_baud_clock_out_o,
    input wire logic rx_clock_i,
    output logic rx_tick_o,
    // Modem pins
    input wire logic cts_n_i,
    input wire logic dsr_n_i,
    input wire logic dcd_n_i,
    output logic dtr_n_o,
    // Serial engine side
    input wire logic [7:0] rx_data_i,
    input wire logic [7:0] line_status_i,
    input wire logic rx_error_i,
    input wire logic rx_data_avail_i,
    input wire logic rx_timeout_i,
    input wire logic fifo_mode_i,
    input wire logic thr_empty_i,
    output logic rx_data_rd_o,
    output logic thr_wr_o,
    output logic [7:0] thr_data_o,
    output logic [7:0] line_ctrl_o
);

    // Two-flop synchronisers for every pin input; idle reset levels avoid a false change after reset
    localparam int NSYNC = 21;
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] pins_s1_q;
    logic [NSYNC-1:0] pins_s2_q;
    assign pins_raw = {chip_sel_high_a_i, chip_sel_high_b_i, register_select_i, rx_clock_i, dcd_n_i, dsr_n_i,
                       cts_n_i, host_data_bus_i, write_strobe_i, read_strobe_i, addr_strobe_n_i, chip_sel_low_n_i};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    pins_s1_q[gi] <= UHMP_SYNC_RST[gi];
                    pins_s2_q[gi] <= UHMP_SYNC_RST[gi];
                end else if (clk_en_i) begin
                    pins_s1_q[gi] <= pins_raw[gi];
                    pins_s2_q[gi] <= pins_s1_q[gi];
                end
            end
        end
    endgenerate

    wire logic cs_low_n_s = pins_s2_q[0];
    wire logic as_n_s = pins_s2_q[1];
    wire logic rd_s = pins_s2_q[2];
    wire logic wr_s = pins_s2_q[3];
    wire logic [7:0] din_s = pins_s2_q[11:4];
    wire logic cts_n_s = pins_s2_q[12];
    wire logic dsr_n_s = pins_s2_q[13];
    wire logic dcd_n_s = pins_s2_q[14];
    wire logic rxclk_s = pins_s2_q[15];

    // Address strobe: transparent while low, held while high
    logic [5:0] sel_live, sel_hold_q, sel_eff;
    assign sel_live = {pins_s2_q[20:19], cs_low_n_s, pins_s2_q[18:16]};
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sel_hold_q <= 6'h08;
        end else if (clk_en_i && !as_n_s) begin
            sel_hold_q <= sel_live;
        end
    end
    assign sel_eff = as_n_s ? sel_hold_q : sel_live;

    logic chip_selected;
    logic [2:0] reg_addr;
    assign chip_selected = sel_eff[5] && sel_eff[4] && !sel_eff[3];
    assign reg_addr = sel_eff[2:0];

    // Host access sequencer; effects land at the end of each strobe
    uhmp_state_t state_q;
    logic [2:0] acc_addr_q;
    logic [7:0] wr_data_q;
    logic rd_done, wr_done;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= UHMP_ST_IDLE;
            acc_addr_q <= 3'h0;
            wr_data_q <= UHMP_RST_BYTE;
        end else if (clk_en_i) begin
            case (state_q)
                UHMP_ST_IDLE: begin
                    if (chip_selected && rd_s) begin
                        state_q <= UHMP_ST_READ;
                        acc_addr_q <= reg_addr;
                    end else if (chip_selected && wr_s) begin
                        state_q <= UHMP_ST_WRITE;
                        acc_addr_q <= reg_addr;
                    end
                end
                UHMP_ST_READ: begin
                    if (!rd_s) begin
                        state_q <= UHMP_ST_IDLE;
                    end
                end
                UHMP_ST_WRITE: begin
                    // Data tracks the strobe, then holds: the host may move it once the strobe drops
                    if (wr_s) begin
                        wr_data_q <= din_s;
                    end else begin
                        state_q <= UHMP_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= UHMP_ST_IDLE;
                end
            endcase
        end
    end

    assign rd_done = clk_en_i && (state_q == UHMP_ST_READ) && !rd_s;
    assign wr_done = clk_en_i && (state_q == UHMP_ST_WRITE) && !wr_s;

    // Programmable registers
    logic [7:0] ier_q, lcr_q, mcr_q, scr_q;
    logic [15:0] divisor_q;
    logic dlab;
    assign dlab = lcr_q[UHMP_LCR_DLAB];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ier_q <= UHMP_RST_BYTE;
            lcr_q <= UHMP_RST_BYTE;
            mcr_q <= UHMP_RST_BYTE;
            scr_q <= UHMP_RST_BYTE;
            divisor_q <= UHMP_RST_DIV;
        end else if (wr_done) begin
            case (acc_addr_q)
                UHMP_OFF_DATA: begin
                    if (dlab) begin
                        divisor_q[7:0] <= wr_data_q;
                    end
                end
                UHMP_OFF_IER: begin
                    if (dlab) begin
                        divisor_q[15:8] <= wr_data_q;
                    end else begin
                        ier_q <= {4'h0, wr_data_q[3:0]};
                    end
                end
                UHMP_OFF_LCR: lcr_q <= wr_data_q;
                UHMP_OFF_MCR: mcr_q <= {2'h0, wr_data_q[5:0]};
                UHMP_OFF_SCR: scr_q <= wr_data_q;
                default: ;
            endcase
        end
    end

    assign line_ctrl_o = lcr_q;
    assign thr_data_o = wr_data_q;
    assign thr_wr_o = wr_done && (acc_addr_q == UHMP_OFF_DATA) && !dlab;
    assign rx_data_rd_o = rd_done && (acc_addr_q == UHMP_OFF_DATA) && !dlab;

    // Baud generator: one clk-wide pulse per divisor period; divisor zero stops it
    logic [15:0] baud_cnt_q;
    logic baud_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            baud_cnt_q <= UHMP_RST_DIV;
            baud_q <= 1'b0;
        end else if (clk_en_i) begin
            if (divisor_q == UHMP_RST_DIV) begin
                baud_cnt_q <= UHMP_RST_DIV;
                baud_q <= 1'b0;
            end else if (baud_cnt_q >= divisor_q - 16'h0001) begin
                baud_cnt_q <= UHMP_RST_DIV;
                baud_q <= 1'b1;
            end else begin
                baud_cnt_q <= baud_cnt_q + 16'h0001;
                baud_q <= 1'b0;
            end
        end
    end
    assign tx_baud_clock_out_o = baud_q;

    // Receive clock is only sampled here; rising edges become ticks
    logic rxclk_d_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rxclk_d_q <= 1'b0;
        end else if (clk_en_i) begin
            rxclk_d_q <= rxclk_s;
        end
    end
    assign rx_tick_o = clk_en_i && rxclk_s && !rxclk_d_q;

    // Modem levels; loopback feeds them from the control bits instead of pins
    logic loop_on, msr_rd_clr;
    logic [2:0] lvl_now, lvl_q, delta_q, changed;
    assign loop_on = mcr_q[UHMP_MCR_LOOP];
    // Clear-to-send reaches only status and interrupt logic, never the engines
    assign lvl_now = loop_on ? {mcr_q[UHMP_MCR_OUT2], mcr_q[UHMP_MCR_DTR], mcr_q[UHMP_MCR_RTS]}
                             : {~dcd_n_s, ~dsr_n_s, ~cts_n_s};
    assign changed = lvl_now ^ lvl_q;
    assign msr_rd_clr = rd_done && (acc_addr_q == UHMP_OFF_MSR);

    // Change flags: a change in the clearing cycle survives the read
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lvl_q <= 3'h0;
            delta_q <= 3'h0;
        end else if (clk_en_i) begin
            lvl_q <= lvl_now;
            delta_q[0] <= changed[0] | (delta_q[0] & ~msr_rd_clr);
            delta_q[1] <= changed[1] | (delta_q[1] & ~msr_rd_clr);
            delta_q[2] <= changed[2] | (delta_q[2] & ~msr_rd_clr);
        end
    end

    logic [7:0] msr_val;
    assign msr_val = {lvl_q[2], 1'b0, lvl_q[1], lvl_q[0], delta_q[2], 1'b0, delta_q[1], delta_q[0]};

    // Transmit-empty interrupt is cleared by a holding-register write or an ident read that reports it
    logic thre_pend_q, thr_empty_d_q, thre_clr;
    logic [3:0] iir_code;
    assign thre_clr = thr_wr_o || (rd_done && acc_addr_q == UHMP_OFF_IIR && iir_code == UHMP_IIR_THRE);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            thre_pend_q <= 1'b0;
            thr_empty_d_q <= 1'b0;
        end else if (clk_en_i) begin
            thr_empty_d_q <= thr_empty_i;
            if (thr_empty_i && !thr_empty_d_q) begin
                thre_pend_q <= 1'b1;
            end else if (wr_done && acc_addr_q == UHMP_OFF_IER && !dlab
                         && wr_data_q[UHMP_IER_THRE] && thr_empty_i) begin
                thre_pend_q <= 1'b1;
            end else if (thre_clr) begin
                thre_pend_q <= 1'b0;
            end
        end
    end

    // Prioritised sources; clear-to-send change ignored under auto flow control
    logic src_rls, src_rda, src_tmo, src_thre, src_ms;
    assign src_rls = ier_q[UHMP_IER_RLS] && rx_error_i;
    assign src_rda = ier_q[UHMP_IER_RDA] && rx_data_avail_i;
    assign src_tmo = ier_q[UHMP_IER_RDA] && rx_timeout_i && fifo_mode_i;
    assign src_thre = ier_q[UHMP_IER_THRE] && thre_pend_q;
    assign src_ms = ier_q[UHMP_IER_MS] && ((delta_q[0] && !mcr_q[UHMP_MCR_AUTO_CTS])
                    || delta_q[1] || delta_q[2]);

    always_comb begin
        if (src_rls) begin
            iir_code = UHMP_IIR_RLS;
        end else if (src_rda) begin
            iir_code = UHMP_IIR_RDA;
        end else if (src_tmo) begin
            iir_code = UHMP_IIR_TMO;
        end else if (src_thre) begin
            iir_code = UHMP_IIR_THRE;
        end else if (src_ms) begin
            iir_code = UHMP_IIR_MS;
        end else begin
            iir_code = UHMP_IIR_NONE;
        end
    end

    logic int_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            int_q <= 1'b0;
        end else if (clk_en_i) begin
            int_q <= src_rls || src_rda || src_tmo || src_thre || src_ms;
        end
    end
    assign interrupt_o = int_q;

    // Read data mux, registered toward the pins
    function automatic logic [7:0] read_mux(input logic [2:0] a);
        logic [7:0] v;
        v = UHMP_RST_BYTE;
        case (a)
            UHMP_OFF_DATA: v = dlab ? divisor_q[7:0] : rx_data_i;
            UHMP_OFF_IER: v = dlab ? divisor_q[15:8] : ier_q;
            UHMP_OFF_IIR: v = {(fifo_mode_i ? UHMP_IIR_FIFO_ON : 2'h0), 2'h0, iir_code};
            UHMP_OFF_LCR: v = lcr_q;
            UHMP_OFF_MCR: v = mcr_q;
            UHMP_OFF_LSR: v = line_status_i;
            UHMP_OFF_MSR: v = msr_val;
            UHMP_OFF_SCR: v = scr_q;
            default: v = UHMP_RST_BYTE;
        endcase
        return v;
    endfunction

    logic [7:0] dout_q;
    logic read_act_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dout_q <= UHMP_RST_BYTE;
            read_act_q <= 1'b0;
        end else if (clk_en_i) begin
            read_act_q <= (state_q == UHMP_ST_READ) && rd_s;
            if (state_q == UHMP_ST_READ) begin
                dout_q <= read_mux(acc_addr_q);
            end
        end
    end

    assign host_data_bus_o = dout_q;
    assign host_data_bus_oe_o = read_act_q;
    assign driver_disable_out_o = !read_act_q;

    // Terminal-ready follows its control bit, forced inactive in loopback
    logic dtr_n_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dtr_n_q <= 1'b1;
        end else if (clk_en_i) begin
            dtr_n_q <= !(mcr_q[UHMP_MCR_DTR] && !loop_on);
        end
    end
    assign dtr_n_o = dtr_n_q;
endmodule

// [uhmp_props.sv]
// Concurrent checks on the host, modem and interrupt pins
`timescale 1ns/10ps
module uhmp_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Host bus
    input wire logic chip_sel_high_a_i,
    input wire logic chip_sel_high_b_i,
    input wire logic chip_sel_low_n_i,
    input wire logic read_strobe_i,
    input wire logic write_strobe_i,
    input wire logic host_data_bus_oe_o,
    input wire logic driver_disable_out_o,
    input wire logic interrupt_o,
    // Clocks, modem, engine
    input wire logic tx_baud_clock_out_o,
    input wire logic rx_tick_o,
    input wire logic dtr_n_o,
    input wire logic thr_wr_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_driver_disable_out_inv;
        driver_disable_out_o == !host_data_bus_oe_o;
    endproperty
    a_driver_disable_out_inv: assert property (p_driver_disable_out_inv) else $error("driver disable not inverse of bus enable");

    property p_sel_read;
        $rose(host_data_bus_oe_o) |-> $past(chip_sel_high_a_i, 2) && $past(chip_sel_high_b_i, 2)
            && !$past(chip_sel_low_n_i, 2) && $past(read_strobe_i, 2);
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("bus driven without selected read");

    // Enable may linger a few cycles after the strobe, never longer
    property p_oe_cause;
        host_data_bus_oe_o |-> read_strobe_i || $past(read_strobe_i) || $past(read_strobe_i, 2)
            || $past(read_strobe_i, 3) || $past(read_strobe_i, 4) || $past(read_strobe_i, 5);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("bus driven outside a read");

    property p_dtr_cause;
        $changed(dtr_n_o) |-> $past(write_strobe_i, 1) || $past(write_strobe_i, 2) || $past(write_strobe_i, 3)
            || $past(write_strobe_i, 4) || $past(write_strobe_i, 5) || $past(write_strobe_i, 6)
            || $past(write_strobe_i, 7) || $past(write_strobe_i, 8);
    endproperty
    a_dtr_cause: assert property (p_dtr_cause) else $error("terminal ready moved without a write");

    property p_rst_out;
        $fell(sys_rst_i) |-> dtr_n_o && !interrupt_o && driver_disable_out_o && !tx_baud_clock_out_o;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not at reset levels");

    // Divisor of one would hold high; never programmed here
    property p_baud_pulse;
        tx_baud_clock_out_o |=> !tx_baud_clock_out_o;
    endproperty
    a_baud_pulse: assert property (p_baud_pulse) else $error("baud pulse wider than one cycle");

    property p_thr_pulse;
        thr_wr_o |-> !write_strobe_i ##1 !thr_wr_o;
    endproperty
    a_thr_pulse: assert property (p_thr_pulse) else $error("holding write pulse misplaced");

    property p_rx_tick;
        rx_tick_o |=> !rx_tick_o;
    endproperty
    a_rx_tick: assert property (p_rx_tick) else $error("receive tick wider than one cycle");
endmodule

bind uhmp_top uhmp_props u_props (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .chip_sel_high_a_i(chip_sel_high_a_i),
    .chip_sel_high_b_i(chip_sel_high_b_i),
    .chip_sel_low_n_i(chip_sel_low_n_i),
    .read_strobe_i(read_strobe_i),
    .write_strobe_i(write_strobe_i),
    .host_data_bus_oe_o(host_data_bus_oe_o),
    .driver_disable_out_o(driver_disable_out_o),
    .interrupt_o(interrupt_o),
    .tx_baud_clock_out_o(tx_baud_clock_out_o),
    .rx_tick_o(rx_tick_o),
    .dtr_n_o(dtr_n_o),
    .thr_wr_o(thr_wr_o)
);

// [uhmp_host_model.sv]
// Behavioural host processor on the parallel bus
`timescale 1ns/10ps
module uhmp_host_model (
    // Clock
    input wire logic clk_i,
    // Bus pins
    output logic chip_sel_high_a_o,
    output logic chip_sel_high_b_o,
    output logic chip_sel_low_n_o,
    output logic addr_strobe_n_o,
    output logic [2:0] register_select_o,
    output logic read_strobe_o,
    output logic write_strobe_o,
    output logic [7:0] data_o,
    // Resolved data bus
    input wire logic [7:0] data_i
);
    initial begin
        {chip_sel_high_a_o, chip_sel_high_b_o, chip_sel_low_n_o} = 3'b010;
        addr_strobe_n_o = 1'b0;
        register_select_o = 3'h0;
        read_strobe_o = 1'b0;
        write_strobe_o = 1'b0;
        data_o = 8'h00;
    end

    // Entered just after an edge; six edges held, then a gap that outlasts both synchronisers
    task automatic access(input logic w, input logic [2:0] cs, input logic [2:0] a, input logic [7:0] d,
        output logic [7:0] q);
        {chip_sel_high_a_o, chip_sel_high_b_o, chip_sel_low_n_o} = cs;
        register_select_o = a;
        data_o = w ? d : ~data_o;
        write_strobe_o = w;
        read_strobe_o = !w;
        // Read data taken a cycle early, clear of the edge that relaunches it
        repeat (5) @(posedge clk_i);
        #1;
        q = data_i;
        @(posedge clk_i);
        #1;
        read_strobe_o = 1'b0;
        write_strobe_o = 1'b0;
        data_o = ~data_o;
        repeat (4) @(posedge clk_i);
        #1;
        {chip_sel_high_a_o, chip_sel_high_b_o, chip_sel_low_n_o} = 3'b010;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    // Raise or lower the address strobe, then let the synchronisers catch up
    task automatic hold_select(input logic h);
        addr_strobe_n_o = h;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
endmodule

// [uhmp_top_tb_top.sv]
// Self-checking bench for the host and modem pin block
`timescale 1ns/10ps
module uhmp_top_tb_top
    import uhmp_pkg::*;
;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic rx_clk = 1'b0;
    logic cts_n = 1'b1, dsr_n = 1'b1, dcd_n = 1'b1, thr_empty = 1'b0, fifo_on = 1'b1;
    logic [2:0] src = 3'h0;
    logic [7:0] dout, hd, dbus, q, thr_d;
    logic oe, driver_disable_out, irq, baud, dtr_n, csa, csb, csl, as_n, rd_s, wr_s, rxt;
    logic [2:0] rsel;
    logic [7:0] lcr;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    assign dbus = oe ? dout : hd;
    always #5 clk_i = ~clk_i;
    always #20 rx_clk = ~rx_clk;

    uhmp_host_model u_host (.clk_i(clk_i), .chip_sel_high_a_o(csa), .chip_sel_high_b_o(csb),
        .chip_sel_low_n_o(csl), .addr_strobe_n_o(as_n), .register_select_o(rsel), .read_strobe_o(rd_s),
        .write_strobe_o(wr_s), .data_o(hd), .data_i(dbus));

    uhmp_top u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .chip_sel_high_a_i(csa),
        .chip_sel_high_b_i(csb), .chip_sel_low_n_i(csl), .addr_strobe_n_i(as_n), .register_select_i(rsel),
        .read_strobe_i(rd_s), .write_strobe_i(wr_s), .host_data_bus_i(dbus), .host_data_bus_o(dout),
        .host_data_bus_oe_o(oe), .driver_disable_out_o(driver_disable_out), .interrupt_o(irq), .tx_baud_clock_out_o(baud),
        .rx_clock_i(rx_clk), .rx_tick_o(rxt), .cts_n_i(cts_n), .dsr_n_i(dsr_n), .dcd_n_i(dcd_n), .dtr_n_o(dtr_n),
        .rx_data_i(8'h5a), .line_status_i(8'h60), .rx_error_i(src[0]), .rx_data_avail_i(src[1]),
        .rx_timeout_i(src[2]), .fifo_mode_i(fifo_on), .thr_empty_i(thr_empty), .rx_data_rd_o(),
        .thr_wr_o(), .thr_data_o(thr_d), .line_ctrl_o(lcr));

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard: whole run is well under this
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end

    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_host.access(1'b1, 3'b110, a, d, q);
    endtask

    task automatic rd(input logic [2:0] a);
        u_host.access(1'b0, 3'b110, a, 8'h00, q);
    endtask

    task automatic t_reset();
        check("reset pins", 8'h05, {3'h0, oe, irq, driver_disable_out, baud, dtr_n});
        $display("reset test done");
    endtask

    task automatic t_dtr();
        logic [2:0] bad [3] = '{3'b010, 3'b100, 3'b111};
        foreach (bad[i]) begin
            u_host.access(1'b1, bad[i], UHMP_OFF_MCR, 8'h01, q);
            check("unselected write", 8'h01, {7'h0, dtr_n});
        end
        wr(UHMP_OFF_MCR, 8'h01);
        check("dtr set", 8'h00, {7'h0, dtr_n});
        wr(UHMP_OFF_MCR, 8'h11);
        check("dtr loop", 8'h01, {7'h0, dtr_n});
        wr(UHMP_OFF_MCR, 8'h01);
        wr(UHMP_OFF_MCR, 8'h00);
        check("dtr clear", 8'h01, {7'h0, dtr_n});
        u_host.hold_select(1'b1);
        wr(UHMP_OFF_MCR, 8'h01);
        check("held deselect", 8'h01, {7'h0, dtr_n});
        u_host.hold_select(1'b0);
        $display("dtr test done");
    endtask

    task automatic t_msr();
        rd(UHMP_OFF_MSR);
        cts_n = 1'b0;
        dcd_n = 1'b0;
        settle(8);
        rd(UHMP_OFF_MSR);
        check("msr levels deltas", 8'h99, q);
        rd(UHMP_OFF_MSR);
        check("msr cleared", 8'h90, q);
        dsr_n = 1'b0;
        settle(8);
        rd(UHMP_OFF_MSR);
        check("msr dsr", 8'hb2, q);
        {cts_n, dsr_n, dcd_n} = 3'b111;
        settle(8);
        rd(UHMP_OFF_MSR);
        check("msr release", 8'h0b, q);
        $display("modem status test done");
    endtask

    task automatic t_modem_irq();
        wr(UHMP_OFF_IER, 8'h08);
        dcd_n = 1'b0;
        settle(8);
        check("irq dcd", 8'h01, {7'h0, irq});
        rd(UHMP_OFF_MSR);
        check("msr dcd", 8'h88, q);
        check("irq served", 8'h00, {7'h0, irq});
        dsr_n = 1'b0;
        settle(8);
        check("irq dsr", 8'h01, {7'h0, irq});
        rd(UHMP_OFF_MSR);
        wr(UHMP_OFF_MCR, 8'h20);
        cts_n = 1'b0;
        settle(8);
        check("irq auto cts", 8'h00, {7'h0, irq});
        wr(UHMP_OFF_MCR, 8'h00);
        check("irq cts", 8'h01, {7'h0, irq});
        rd(UHMP_OFF_MSR);
        wr(UHMP_OFF_IER, 8'h00);
        {cts_n, dsr_n, dcd_n} = 3'b111;
        settle(8);
        check("irq masked", 8'h00, {7'h0, irq});
        rd(UHMP_OFF_MSR);
        $display("modem interrupt test done");
    endtask

    task automatic t_sources();
        logic [7:0] ier [3] = '{8'h04, 8'h01, 8'h01};
        logic [7:0] code [3] = '{8'hc6, 8'hc4, 8'hcc};
        for (int i = 0; i < 3; i++) begin
            src[i] = 1'b1;
            settle(4);
            check("irq source masked", 8'h00, {7'h0, irq});
            wr(UHMP_OFF_IER, ier[i]);
            check("irq source", 8'h01, {7'h0, irq});
            rd(UHMP_OFF_IIR);
            check("iir code", code[i], q);
            src = 3'h0;
            settle(4);
            check("irq source gone", 8'h00, {7'h0, irq});
            wr(UHMP_OFF_IER, 8'h00);
        end
        wr(UHMP_OFF_IER, 8'h02);
        thr_empty = 1'b1;
        settle(4);
        check("irq thre", 8'h01, {7'h0, irq});
        rd(UHMP_OFF_IIR);
        check("iir thre", 8'hc2, q);
        check("irq thre served", 8'h00, {7'h0, irq});
        wr(UHMP_OFF_IER, 8'h00);
        fifo_on = 1'b0;
        rd(UHMP_OFF_IIR);
        check("iir none", 8'h01, q);
        $display("interrupt source test done");
    endtask

    task automatic t_baud();
        int n;
        int m;
        n = 0;
        m = 0;
        wr(UHMP_OFF_LCR, 8'h80);
        wr(UHMP_OFF_DATA, 8'h04);
        wr(UHMP_OFF_IER, 8'h00);
        wr(UHMP_OFF_LCR, 8'h03);
        check("line control", 8'h03, lcr);
        repeat (40) begin
            settle(1);
            if (baud === 1'b1) begin
                n++;
            end
            if (rxt === 1'b1) begin
                m++;
            end
        end
        check("baud pulses", 8'h0a, n[7:0]);
        check("receive ticks", 8'h0a, m[7:0]);
        wr(UHMP_OFF_DATA, 8'h3c);
        check("holding data", 8'h3c, thr_d);
        rd(UHMP_OFF_DATA);
        check("receive data", 8'h5a, q);
        $display("baud test done");
    endtask

    initial begin
        settle(12);
        sys_rst_i = 1'b0;
        settle(4);
        t_reset();
        t_dtr();
        t_msr();
        t_modem_irq();
        t_sources();
        t_baud();
        close_out();
    end
endmodule
